/* tig_pkg.sv */
package tig_pkg;
    // ======================================================
    // bus and register map
    localparam int AW = 8;
    localparam int DW = 32;
    localparam logic [AW-1:0] A_CTRL = 8'h00;
    localparam logic [AW-1:0] A_GAIN = 8'h04;
    localparam logic [AW-1:0] A_DACA = 8'h08;
    localparam logic [AW-1:0] A_DACB = 8'h0c;
    localparam logic [AW-1:0] A_STAT = 8'h10;
    // ======================================================
    // control word fields
    localparam int C_INTP = 0;
    localparam int C_PLL = 2;
    localparam int C_FAST = 3;
    localparam int C_SLEEP = 4;
    localparam int C_FPD = 5;
    localparam int C_IFM = 6;
    // per-converter word fields
    localparam int D_CRS = 0;
    localparam int D_FINE = 2;
    localparam int D_OFS = 8;
    localparam int D_NEG = 18;
    // status word fields
    localparam int S_PIN = 0;
    localparam int S_ACT = 1;
    localparam int S_CUR = 2;
    localparam int S_UND = 3;
    // ======================================================
    // widths
    localparam int SW = 12;
    localparam int PGA_W = 8;
    localparam int CRS_W = 2;
    localparam int FINE_W = 6;
    localparam int OFS_W = 10;
    localparam int RC_W = 12;
    localparam int TAPS1 = 39;
    localparam int TAPS2 = 15;
    // ======================================================
    // timing
    localparam int CLK_MHZ = 200;
    localparam int RECOV_NS = 10000;
    localparam logic [RC_W-1:0] RECOV_CYC =
        RC_W'((RECOV_NS * CLK_MHZ + 999) / 1000);
    // ======================================================
    // modes and states
    typedef enum logic [1:0] {I_1X, I_2X, I_4X, I_RSV} tig_intp_e;
    typedef enum logic [1:0] {CRS_FULL, CRS_HALF, CRS_ELEVENTH,
        CRS_RSV} tig_crs_e;
    typedef enum logic [1:0] {IF_TWO_PORT, IF_HALF_IL, IF_FULL_IL,
        IF_CLONE} tig_ifm_e;
    typedef enum logic [1:0] {PW_ON, PW_OFF, PW_WAKE} tig_pwr_e;
endpackage

/* tig_ctrl.sv */
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps

// =========================================================
// one two-times stage: zero-stuffed delay line, averaging kernel
module tig_hbf #(
    parameter int TAPS = tig_pkg::TAPS1,
    parameter int W = tig_pkg::SW
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic en,
    input wire logic ld,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    localparam int AW2 = W + $clog2(TAPS) + 2;
    localparam logic signed [AW2-1:0] MAXV = AW2'((1 <<< (W - 1)) - 1);
    localparam logic signed [AW2-1:0] MINV = -AW2'(1 <<< (W - 1));
    localparam logic signed [AW2-1:0] DIV = AW2'(TAPS);
    typedef struct packed {
        logic [TAPS-1:0][W-1:0] line;
        logic [W-1:0] out;
    } tig_hbf_s;
    tig_hbf_s s_r, s_nxt;

    always_comb begin
        logic signed [AW2-1:0] acc;
        logic signed [AW2-1:0] q;
        acc = '0;
        q = '0;
        s_nxt = s_r;
        for (int i = 0; i < TAPS; i++) begin
            acc = acc + AW2'($signed(s_r.line[i]));
        end
        // zero-stuffing halves the energy, so the kernel sum is doubled
        q = (acc <<< 1) / DIV;
        if (q > MAXV) begin
            q = MAXV;
        end else if (q < MINV) begin
            q = MINV;
        end
        if (en) begin
            s_nxt.line = {s_r.line[TAPS-2:0], ld ? din : W'(0)};
            s_nxt.out = q[W-1:0];
        end
    end

    // contents survive a full power-down; stale words must be flushed
    always_ff @(posedge CLK) begin
        if (RST) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign dout = s_r.out;
endmodule // tig_hbf

// =========================================================
module tig_ctrl #(
    parameter int TAPS1 = tig_pkg::TAPS1,
    parameter int TAPS2 = tig_pkg::TAPS2
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [tig_pkg::AW-1:0] PADDR,
    input wire logic [tig_pkg::DW-1:0] PWDATA,
    output logic [tig_pkg::DW-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic TX_POWERDOWN_PIN,
    input wire logic DAC_SIDE_CLOCK_INPUT,
    input wire logic TX_VALID,
    input wire logic TX_SYNC,
    input wire logic [tig_pkg::SW-1:0] TX_A_DATA,
    input wire logic [tig_pkg::SW-1:0] TX_B_DATA,
    output logic TX_READY,
    output logic [tig_pkg::SW-1:0] DAC_A_CODE,
    output logic [tig_pkg::SW-1:0] DAC_B_CODE,
    output logic DAC_CURRENT_ON,
    output logic TX_ACTIVE,
    output logic [tig_pkg::PGA_W-1:0] SHARED_TX_GAIN,
    output logic FAST_GAIN_SETTLE_OPTION,
    output logic [tig_pkg::CRS_W-1:0] COARSE_A,
    output logic [tig_pkg::CRS_W-1:0] COARSE_B,
    output logic [tig_pkg::FINE_W-1:0] FINE_A,
    output logic [tig_pkg::FINE_W-1:0] FINE_B,
    output logic [tig_pkg::OFS_W-1:0] OFFSET_A,
    output logic [tig_pkg::OFS_W-1:0] OFFSET_B,
    output logic OFFSET_NEG_A,
    output logic OFFSET_NEG_B
);
    localparam int SW = tig_pkg::SW;

    typedef struct packed {
        logic [tig_pkg::DW-1:0] prdata;
        logic pready;
        logic pslverr;
        logic [1:0] intp;
        logic pll;
        logic fast;
        logic sleep;
        logic fpd;
        logic [1:0] ifm;
        logic [tig_pkg::PGA_W-1:0] pga;
        logic [1:0][tig_pkg::CRS_W-1:0] crs;
        logic [1:0][tig_pkg::FINE_W-1:0] fine;
        logic [1:0][tig_pkg::OFS_W-1:0] ofs;
        logic [1:0] neg;
        tig_pkg::tig_pwr_e pwr;
        logic [tig_pkg::RC_W-1:0] rcnt;
        logic ck1, ck2, ck3;
        logic pd1, pd2;
        logic [1:0] ph;
        logic [1:0][SW-1:0] hold;
        logic [1:0][SW-1:0] x;
        logic pend;
        logic under;
        logic ready;
        logic t_d, en1, ld1, en2, ld2;
        logic [1:0][SW-1:0] dac;
        logic cur;
        logic act;
    } tig_ctrl_s;
    tig_ctrl_s s_r, s_nxt;

    logic [1:0][SW-1:0] s1o, s2o;
    logic t;

    // =====================================================
    // register decode for the error path; reads decode PADDR in their own case
    function automatic logic mapped(input logic [tig_pkg::AW-1:0] a);
        return a == tig_pkg::A_CTRL || a == tig_pkg::A_GAIN ||
            a == tig_pkg::A_DACA || a == tig_pkg::A_DACB ||
            a == tig_pkg::A_STAT;
    endfunction

    function automatic logic [tig_pkg::DW-1:0] dac_word(
        input tig_ctrl_s s, input int c);
        logic [tig_pkg::DW-1:0] w;
        w = '0;
        w[tig_pkg::D_CRS +: tig_pkg::CRS_W] = s.crs[c];
        w[tig_pkg::D_FINE +: tig_pkg::FINE_W] = s.fine[c];
        w[tig_pkg::D_OFS +: tig_pkg::OFS_W] = s.ofs[c];
        w[tig_pkg::D_NEG] = s.neg[c];
        return w;
    endfunction

    // =====================================================
    // update tick: multiplied clock or synchronised pin edge
    always_comb begin
        logic run;
        run = s_r.pwr == tig_pkg::PW_ON && !s_r.fpd;
        t = run && (s_r.pll || (s_r.ck2 && !s_r.ck3));
    end

    // =====================================================
    always_comb begin
        logic setup, wr, take;
        logic [1:0] last;
        logic [tig_pkg::DW-1:0] rd;
        int c;
        setup = PSEL && !PENABLE;
        wr = PSEL && PENABLE && s_r.pready && PWRITE;
        take = 1'b0;
        last = 2'h0;
        rd = '0;
        c = 0;
        s_nxt = s_r;

        // pin synchronisers
        s_nxt.ck1 = DAC_SIDE_CLOCK_INPUT;
        s_nxt.ck2 = s_r.ck1;
        s_nxt.ck3 = s_r.ck2;
        s_nxt.pd1 = TX_POWERDOWN_PIN;
        s_nxt.pd2 = s_r.pd1;

        // bus slave: answers in the first access cycle, always on
        s_nxt.pready = setup;
        s_nxt.pslverr = setup && !mapped(PADDR);
        case (PADDR)
            tig_pkg::A_CTRL: begin
                rd[tig_pkg::C_INTP +: 2] = s_r.intp;
                rd[tig_pkg::C_PLL] = s_r.pll;
                rd[tig_pkg::C_FAST] = s_r.fast;
                rd[tig_pkg::C_SLEEP] = s_r.sleep;
                rd[tig_pkg::C_FPD] = s_r.fpd;
                rd[tig_pkg::C_IFM +: 2] = s_r.ifm;
            end
            tig_pkg::A_GAIN: rd[tig_pkg::PGA_W-1:0] = s_r.pga;
            tig_pkg::A_DACA: rd = dac_word(s_r, 0);
            tig_pkg::A_DACB: rd = dac_word(s_r, 1);
            tig_pkg::A_STAT: begin
                rd[tig_pkg::S_PIN] = s_r.pd2;
                rd[tig_pkg::S_ACT] = s_r.act;
                rd[tig_pkg::S_CUR] = s_r.cur;
                rd[tig_pkg::S_UND] = s_r.under;
            end
            default: rd = '0;
        endcase
        s_nxt.prdata = setup ? rd : '0;

        if (wr) begin
            case (PADDR)
                tig_pkg::A_CTRL: begin
                    s_nxt.intp = PWDATA[tig_pkg::C_INTP +: 2];
                    s_nxt.pll = PWDATA[tig_pkg::C_PLL];
                    s_nxt.fast = PWDATA[tig_pkg::C_FAST];
                    s_nxt.sleep = PWDATA[tig_pkg::C_SLEEP];
                    s_nxt.fpd = PWDATA[tig_pkg::C_FPD];
                    s_nxt.ifm = PWDATA[tig_pkg::C_IFM +: 2];
                end
                tig_pkg::A_GAIN:
                    s_nxt.pga = PWDATA[tig_pkg::PGA_W-1:0];
                tig_pkg::A_DACA, tig_pkg::A_DACB: begin
                    // only the addressed converter changes
                    c = PADDR == tig_pkg::A_DACB ? 1 : 0;
                    s_nxt.crs[c] =
                        PWDATA[tig_pkg::D_CRS +: tig_pkg::CRS_W];
                    s_nxt.fine[c] =
                        PWDATA[tig_pkg::D_FINE +: tig_pkg::FINE_W];
                    s_nxt.ofs[c] =
                        PWDATA[tig_pkg::D_OFS +: tig_pkg::OFS_W];
                    s_nxt.neg[c] = PWDATA[tig_pkg::D_NEG];
                end
                tig_pkg::A_STAT:
                    if (PWDATA[tig_pkg::S_UND]) begin
                        s_nxt.under = 1'b0;
                    end
                default: s_nxt.intp = s_nxt.intp;
            endcase
        end

        // pin power-down and its recovery wait
        case (s_r.pwr)
            tig_pkg::PW_ON:
                if (s_r.pd2) begin
                    s_nxt.pwr = tig_pkg::PW_OFF;
                end
            tig_pkg::PW_OFF:
                if (!s_r.pd2) begin
                    s_nxt.pwr = tig_pkg::PW_WAKE;
                    s_nxt.rcnt = '0;
                end
            tig_pkg::PW_WAKE:
                if (s_r.pd2) begin
                    s_nxt.pwr = tig_pkg::PW_OFF;
                end else if (s_r.rcnt == tig_pkg::RECOV_CYC - 1'b1) begin
                    s_nxt.pwr = tig_pkg::PW_ON;
                end else begin
                    s_nxt.rcnt = s_r.rcnt + 1'b1;
                end
            default: s_nxt.pwr = tig_pkg::PW_ON;
        endcase

        // phase of the update tick within one input sample
        case (s_r.intp)
            tig_pkg::I_2X: last = 2'h1;
            tig_pkg::I_4X: last = 2'h3;
            default: last = 2'h0;
        endcase
        if (t) begin
            s_nxt.ph = s_r.ph >= last ? 2'h0 : s_r.ph + 2'h1;
        end
        take = t && s_r.ph == 2'h0;

        // stage enables; bypass leaves both idle
        s_nxt.t_d = t;
        s_nxt.en1 = 1'b0;
        s_nxt.ld1 = 1'b0;
        s_nxt.en2 = 1'b0;
        s_nxt.ld2 = 1'b0;
        case (s_r.intp)
            tig_pkg::I_2X: begin
                s_nxt.en1 = t;
                s_nxt.ld1 = take;
            end
            tig_pkg::I_4X: begin
                // first stage sees the input rate, at half tick rate
                s_nxt.en1 = t && !s_r.ph[0];
                s_nxt.ld1 = take;
                s_nxt.en2 = t;
                s_nxt.ld2 = t && !s_r.ph[0];
            end
            default: s_nxt.en1 = 1'b0;
        endcase

        // sample hand-off; a missing sample feeds zero and is flagged
        if (take) begin
            s_nxt.x = s_r.pend ? s_r.hold : '0;
            s_nxt.pend = 1'b0;
            if (!s_r.pend) begin
                s_nxt.under = 1'b1;
            end
        end
        if (TX_VALID && s_r.ready) begin
            if (s_r.ifm == tig_pkg::IF_TWO_PORT) begin
                s_nxt.hold[0] = TX_A_DATA;
                s_nxt.hold[1] = TX_B_DATA;
                s_nxt.pend = 1'b1;
            end else if (TX_SYNC) begin
                s_nxt.hold[0] = TX_A_DATA;
            end else begin
                s_nxt.hold[1] = TX_A_DATA;
                s_nxt.pend = 1'b1;
            end
        end
        s_nxt.ready = !s_nxt.pend;

        // converter codes follow the selected stage
        if (s_r.t_d) begin
            case (s_r.intp)
                tig_pkg::I_2X: s_nxt.dac = s1o;
                tig_pkg::I_4X: s_nxt.dac = s2o;
                default: s_nxt.dac = s_r.x;
            endcase
        end

        s_nxt.act = s_nxt.pwr == tig_pkg::PW_ON && !s_nxt.fpd;
        // sleep drops only the current, clocks keep running
        s_nxt.cur = s_nxt.act && !s_nxt.sleep;
    end

    // =====================================================
    // reset values give unity coarse, 0 dB and zero fine gain
    always_ff @(posedge CLK) begin
        if (RST) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // =====================================================
    for (genvar g = 0; g < 2; g++) begin : g_ch
        tig_hbf #(.TAPS(TAPS1), .W(SW)) u_s1 (
            .CLK(CLK),
            .RST(RST),
            .en(s_r.en1),
            .ld(s_r.ld1),
            .din(s_r.x[g]),
            .dout(s1o[g])
        );
        tig_hbf #(.TAPS(TAPS2), .W(SW)) u_s2 (
            .CLK(CLK),
            .RST(RST),
            .en(s_r.en2),
            .ld(s_r.ld2),
            .din(s1o[g]),
            .dout(s2o[g])
        );
    end

    assign PRDATA = s_r.prdata;
    assign PREADY = s_r.pready;
    assign PSLVERR = s_r.pslverr;
    assign TX_READY = s_r.ready;
    assign DAC_A_CODE = s_r.dac[0];
    assign DAC_B_CODE = s_r.dac[1];
    assign DAC_CURRENT_ON = s_r.cur;
    assign TX_ACTIVE = s_r.act;
    assign SHARED_TX_GAIN = s_r.pga;
    assign FAST_GAIN_SETTLE_OPTION = s_r.fast;
    assign COARSE_A = s_r.crs[0];
    assign COARSE_B = s_r.crs[1];
    assign FINE_A = s_r.fine[0];
    assign FINE_B = s_r.fine[1];
    assign OFFSET_A = s_r.ofs[0];
    assign OFFSET_B = s_r.ofs[1];
    assign OFFSET_NEG_A = s_r.neg[0];
    assign OFFSET_NEG_B = s_r.neg[1];

    // =====================================================
    property p_two_x;
        @(posedge CLK) disable iff (RST)
        s_r.intp == tig_pkg::I_2X |=> !s_r.en2;
    endproperty
    a_two_x: assert property (p_two_x) else $error("stage2 on at 2x");

    property p_byp;
        @(posedge CLK) disable iff (RST)
        s_r.intp == tig_pkg::I_1X && s_r.t_d |=> DAC_A_CODE == $past(s_r.x[0]);
    endproperty
    a_byp: assert property (p_byp) else $error("bypass path wrong");

    property p_half;
        @(posedge CLK) disable iff (RST)
        s_r.intp == tig_pkg::I_4X && s_r.pll && $stable(s_r.intp) && t
            ##1 t |-> s_r.en1 != $past(s_r.en1);
    endproperty
    a_half: assert property (p_half) else $error("stage1 rate");

    property p_pin_tick;
        @(posedge CLK) disable iff (RST)
        !s_r.pll && s_r.ck2 == s_r.ck3 |-> !t;
    endproperty
    a_pin_tick: assert property (p_pin_tick) else $error("stray tick");

    property p_wake;
        @(posedge CLK) disable iff (RST)
        s_r.pwr == tig_pkg::PW_OFF && !s_r.pd2 |=>
            !TX_ACTIVE ##1 (!TX_ACTIVE && !t) [*8];
    endproperty
    a_wake: assert property (p_wake) else $error("early wake");

    property p_sleep;
        @(posedge CLK) disable iff (RST)
        s_r.sleep && !s_r.fpd && s_r.pwr == tig_pkg::PW_ON |->
            !DAC_CURRENT_ON && TX_ACTIVE && (t || !s_r.pll);
    endproperty
    a_sleep: assert property (p_sleep) else $error("current in sleep");

    property p_fpd;
        @(posedge CLK) disable iff (RST)
        s_r.fpd |-> !t && !TX_ACTIVE;
    endproperty
    a_fpd: assert property (p_fpd) else $error("ticks in power-down");

    property p_bus_pd;
        @(posedge CLK) disable iff (RST)
        s_r.pd2 && PSEL && !PENABLE |=> PREADY;
    endproperty
    a_bus_pd: assert property (p_bus_pd) else $error("bus dead");

    property p_iso;
        @(posedge CLK) disable iff (RST)
        PSEL && PENABLE && PREADY && PWRITE && PADDR == tig_pkg::A_DACA
            |=> $stable(s_r.fine[1]) && $stable(s_r.ofs[1]);
    endproperty
    a_iso: assert property (p_iso) else $error("channel B disturbed");
endmodule // tig_ctrl

/* tig_src_model.sv */
`timescale 1ns/1ps
// ======================================================
// sample source: streams one fixed pair, paced by the ready level
module tig_src_model (
    input wire logic CLK,
    input wire logic RST,
    input wire logic run,
    input wire logic il,
    input wire logic [tig_pkg::SW-1:0] a,
    input wire logic [tig_pkg::SW-1:0] b,
    input wire logic ready,
    output logic valid,
    output logic sync,
    output logic [tig_pkg::SW-1:0] da,
    output logic [tig_pkg::SW-1:0] db,
    output int pairs
);
    logic ph;
    logic take;
    logic ph_n;
    assign take = valid & ready;
    assign ph_n = il & (take ? ~ph : ph);
    always_ff @(posedge CLK) begin
        if (RST) begin
            valid <= 1'b0;
            sync <= 1'b1;
            da <= '0;
            db <= '0;
            ph <= 1'b0;
            pairs <= 0;
        end else if (!run) begin
            // idle lines keep moving so a stale word cannot pass by luck
            valid <= 1'b0;
            sync <= ~sync;
            da <= ~da;
            db <= ~db;
            ph <= 1'b0;
        end else begin
            if (take && (!il || ph)) begin
                pairs <= pairs + 1;
            end
            ph <= ph_n;
            valid <= 1'b1;
            sync <= ~ph_n;
            da <= ph_n ? b : a;
            db <= il ? ~db : b;
        end
    end
endmodule // tig_src_model

/* tx_interp_gain_power_ctrl_tb_top.sv */
`timescale 1ns/1ps
module tx_interp_gain_power_ctrl_tb_top;
    logic CLK, RST, psel, pen, pwr, pin, ck_en, run, il, errv;
    logic dsc = 1'b0;
    logic [2:0] dcnt = 3'h0;
    logic [7:0] pad;
    logic [31:0] pwd, rdv, w, prd;
    logic [11:0] sa, sb, da, db, qa, qb;
    logic prdy, perr, trdy, tv, ts, cur, act, fast, na_o, nb_o;
    logic [7:0] gain;
    logic [1:0] ca, cb;
    logic [5:0] fa_o, fb_o;
    logic [9:0] oa_o, ob_o;
    int pairs, mismatches, checks;
    tig_ctrl u_dut (.CLK(CLK), .RST(RST), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(pad), .PWDATA(pwd), .PRDATA(prd),
        .PREADY(prdy), .PSLVERR(perr), .TX_POWERDOWN_PIN(pin),
        .DAC_SIDE_CLOCK_INPUT(dsc), .TX_VALID(tv), .TX_SYNC(ts),
        .TX_A_DATA(da), .TX_B_DATA(db), .TX_READY(trdy),
        .DAC_A_CODE(qa), .DAC_B_CODE(qb), .DAC_CURRENT_ON(cur),
        .TX_ACTIVE(act), .SHARED_TX_GAIN(gain),
        .FAST_GAIN_SETTLE_OPTION(fast), .COARSE_A(ca), .COARSE_B(cb),
        .FINE_A(fa_o), .FINE_B(fb_o), .OFFSET_A(oa_o), .OFFSET_B(ob_o),
        .OFFSET_NEG_A(na_o), .OFFSET_NEG_B(nb_o));
    tig_src_model u_src (.CLK(CLK), .RST(RST), .run(run), .il(il),
        .a(sa), .b(sb), .ready(trdy), .valid(tv), .sync(ts), .da(da),
        .db(db), .pairs(pairs));
    // ======================================================
    // clocks and watchdog
    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    // slow converter clock on the pin: one rising edge per 16 cycles
    always @(posedge CLK) begin
        if (ck_en) begin
            dcnt <= dcnt + 3'h1;
            if (dcnt == 3'h7) begin
                dsc <= ~dsc;
            end
        end
    end
    initial begin
        repeat (20000) @(posedge CLK);
        mismatches++;
        test_done();
    end
    // ======================================================
    // tasks
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // apb read data is taken at the same edge that samples pready
    task automatic apb(input logic wr, input logic [7:0] ad,
        input logic [31:0] wd);
        @(posedge CLK);
        psel <= 1'b1;
        pwr <= wr;
        pad <= ad;
        pwd <= wd;
        @(posedge CLK);
        pen <= 1'b1;
        do begin
            @(posedge CLK);
        end while (prdy !== 1'b1);
        rdv = prd;
        errv = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic meas(input int cyc, output int c);
        int p0;
        p0 = pairs;
        repeat (cyc) @(posedge CLK);
        c = pairs - p0;
    endtask
    function automatic logic [31:0] dw(input logic [1:0] c,
        input logic [5:0] f, input logic [9:0] o, input logic ng);
        return 32'(c) | 32'(f) << tig_pkg::D_FINE
            | 32'(o) << tig_pkg::D_OFS | 32'(ng) << tig_pkg::D_NEG;
    endfunction
    // ======================================================
    // main sequence
    initial begin
        int cnt[3];
        int c, n;
        logic [5:0] fa, fb;
        logic [9:0] oa, ob;
        logic na, nb;
        logic [31:0] wa, wb;
        {psel, pen, pwr, pin, ck_en, run, il} = '0;
        pad = '0;
        pwd = '0;
        sa = '0;
        sb = '0;
        RST = 1'b1;
        void'($urandom(32'h3cc38e80));
        repeat (16) @(posedge CLK);
        RST <= 1'b0;
        repeat (4) @(posedge CLK);
        chk("coarse_a", 0, 32'(ca));
        chk("coarse_b", 0, 32'(cb));
        chk("gain", 0, 32'(gain));
        chk("fine_a", 0, 32'(fa_o));
        chk("fine_b", 0, 32'(fb_o));
        for (int k = 0; k < 3; k++) begin
            {fa, oa, na} = 17'($urandom());
            {fb, ob, nb} = 17'($urandom());
            wa = dw(2'(k), fa, oa, na);
            wb = dw(2'(2 - k), fb, ob, nb);
            apb(1'b1, tig_pkg::A_DACB, wb);
            apb(1'b1, tig_pkg::A_DACA, wa);
            @(posedge CLK);
            chk("coarse_a", k, 32'(ca));
            chk("coarse_b", 2 - k, 32'(cb));
            chk("fine_a", 32'(fa), 32'(fa_o));
            chk("fine_b", 32'(fb), 32'(fb_o));
            chk("ofs_a", 32'(oa), 32'(oa_o));
            chk("ofs_b", 32'(ob), 32'(ob_o));
            chk("neg_a", 32'(na), 32'(na_o));
            chk("neg_b", 32'(nb), 32'(nb_o));
            apb(1'b0, tig_pkg::A_DACB, 0);
            chk("dacb rd", wb, rdv);
        end
        w = $urandom() & 32'hff;
        apb(1'b1, tig_pkg::A_GAIN, w);
        @(posedge CLK);
        chk("gain", w, 32'(gain));
        apb(1'b1, tig_pkg::A_CTRL, 32'h1 << tig_pkg::C_FAST);
        @(posedge CLK);
        chk("fast", 1, 32'(fast));
        apb(1'b0, 8'h20, 0);
        chk("slverr", 1, 32'(errv));
        chk("unmapped", 0, rdv);
        // a tick every 16 cycles leaves room for a whole pair per tick
        ck_en <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            run <= 1'b0;
            {sa, sb} <= 24'($urandom());
            apb(1'b1, tig_pkg::A_CTRL, 32'(m) << tig_pkg::C_IFM);
            il <= (m != 0);
            run <= 1'b1;
            repeat (60) @(posedge CLK);
            chk("dac_a", 32'(sa), 32'(qa));
            chk("dac_b", 32'(sb), 32'(qb));
        end
        run <= 1'b0;
        il <= 1'b0;
        ck_en <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, tig_pkg::A_CTRL, 32'h4 | 32'(i));
            run <= 1'b1;
            repeat (40) @(posedge CLK);
            meas(800, cnt[i]);
        end
        chk("rate4x", 1, 32'(cnt[2] >= 198 && cnt[2] <= 202));
        chk("rate2x", 1, 32'(cnt[1] >= cnt[2] && cnt[1] <= 402));
        chk("rate1x", 1, 32'(cnt[0] >= cnt[1]));
        run <= 1'b0;
        repeat (30) @(posedge CLK);
        apb(1'b0, tig_pkg::A_STAT, 0);
        chk("underrun", 1, 32'(rdv[tig_pkg::S_UND]));
        run <= 1'b1;
        repeat (30) @(posedge CLK);
        apb(1'b1, tig_pkg::A_STAT, 32'h8);
        apb(1'b0, tig_pkg::A_STAT, 0);
        chk("und clr", 0, 32'(rdv[tig_pkg::S_UND]));
        apb(1'b1, tig_pkg::A_CTRL, 0);
        ck_en <= 1'b1;
        repeat (40) @(posedge CLK);
        meas(800, c);
        chk("pin ticks", 1, 32'(c >= 48 && c <= 52));
        ck_en <= 1'b0;
        apb(1'b1, tig_pkg::A_CTRL, 32'h14);
        repeat (3) @(posedge CLK);
        chk("sleep cur", 0, 32'(cur));
        chk("sleep act", 1, 32'(act));
        apb(1'b1, tig_pkg::A_CTRL, 32'h4);
        repeat (3) @(posedge CLK);
        chk("wake cur", 1, 32'(cur));
        apb(1'b1, tig_pkg::A_CTRL, 32'h24);
        repeat (3) @(posedge CLK);
        chk("fpd act", 0, 32'(act));
        chk("fpd cur", 0, 32'(cur));
        apb(1'b1, tig_pkg::A_GAIN, 32'h5a);
        apb(1'b0, tig_pkg::A_GAIN, 0);
        chk("fpd rd", 32'h5a, rdv);
        apb(1'b1, tig_pkg::A_CTRL, 32'h4);
        repeat (40) @(posedge CLK);
        chk("fpd exit", 1, 32'(act));
        pin <= 1'b1;
        repeat (6) @(posedge CLK);
        chk("pin act", 0, 32'(act));
        apb(1'b0, tig_pkg::A_STAT, 0);
        chk("pin stat", 1, 32'(rdv[tig_pkg::S_PIN]));
        meas(100, c);
        chk("pin hold", 1, 32'(c <= 1));
        pin <= 1'b0;
        n = 0;
        while (act !== 1'b1 && n < 3000) begin
            @(posedge CLK);
            n++;
        end
        chk("recover", 1, 32'(n <= tig_pkg::RECOV_CYC + 8));
        test_done();
    end
endmodule // tx_interp_gain_power_ctrl_tb_top
